// [rtl/scl_link.sv]
/*
  Exchange-level control of one link end: state sequencing, flow-control credit,
  receiver error detection, exchange-of-silence recovery and APB registers.
  Assumes a character decoder and a character encoder on mclk_in beside it; the raw
  data and strobe lines arrive asynchronously and are synchronised here.
*/
// Behaviour
// - each host room pulse for 8 characters sends one FCT to the far end, unless granted plus pending credit already exceeds 48
// - each received FCT adds 8 to transmit credit unless credit already exceeds 48; ready while credit nonzero
// - each sent normal character costs one credit; zero credit blocks the host
// - any receiver error drops sync and credit, forcing reset and re-initialisation
// - invalid character to send is discarded, halts sending, reports a transmit error
// - no data or strobe transition for over 850 ns means disconnect
// - disconnect detection armed only after the first received bit since reset
// - parity failures after the first NULL start error recovery
// - ESC followed by anything but FCT is an escape error and recovers
// - in run, a normal character with no receive credit is a credit error
// - unexpected FCT or character during start-up resets, never reported as link error
// - in run, end marker right after an end marker is an empty packet error
// - disabled or erroring end stops transmitting entirely so both ends fall silent
// - after silence, step through reset sequence to ready, start only when enabled
// - enabled end facing silent peer sends NULLs 12.8 us then falls silent again
// - even disabled, null flag and disconnect timer keep running
// - errors during any start-up state are not reported to the network level
// - in run, disconnect, parity, escape, credit and empty errors raise link error
// - started and connecting states time out after 12.8 us back to reset
// - no FCT is sent before a NULL has been received
`timescale 1ns/1ps
module scl_link (
  input wire logic mclk_in,                        // system clock, 25 MHz
  input wire logic rst_in,                         // asynchronous reset, active high
  input wire scl_pkg::scl_apb_req_t apb_in,        // apb request from the bus master
  output logic [31:0] prdata_out,                  // apb read data
  output logic pready_out,                         // apb ready
  output logic pslverr_out,                        // apb error on unmapped address
  input wire logic rx_data_in,                     // raw data line, asynchronous
  input wire logic rx_strobe_in,                   // raw strobe line, asynchronous
  input wire scl_pkg::scl_rx_ev_t rx_ev_in,        // decoded character from the receiver
  input wire logic rx_room_in,                     // host freed room for 8 characters
  input wire logic tx_valid_in,                    // host offers a character to send
  input wire logic [8:0] tx_char_in,               // bit 8 set marks an end marker
  output logic tx_ready_out,                       // host character taken this cycle
  input wire logic tx_link_ready_in,               // encoder can take a character
  output logic tx_run_out,                         // encoder enabled, idles with NULLs
  output logic tx_fct_out,                         // send one FCT, pulse
  output logic tx_nch_valid_out,                   // send tx_nch_out, pulse
  output logic [8:0] tx_nch_out,                   // normal character to send
  output logic tx_err_out,                         // invalid character discarded, pulse
  output logic link_err_out,                       // link error in run, pulse
  output scl_pkg::scl_err_t link_err_code_out,     // type of the last link error
  output scl_pkg::scl_state_t state_out            // current exchange state
);
  import scl_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  scl_regs_t r;
  scl_regs_t next_r;
  logic fct_go;
  logic nch_slot;

  // one character per slot; wait out the pulse just issued
  assign fct_go = (r.st == SCL_CONNECT || r.st == SCL_RUN) && r.null_seen &&
                  r.fct_pend != 3'h0 && tx_link_ready_in && !r.tx_fct && !r.tx_nch_valid;
  assign nch_slot = r.st == SCL_RUN && !r.tx_halt && r.tx_credit != 6'h00 &&
                    tx_link_ready_in && !fct_go && !r.tx_fct && !r.tx_nch_valid;
  assign tx_ready_out = nch_slot;
  assign pready_out = apb_in.psel && apb_in.penable;
  assign pslverr_out = apb_in.psel && apb_in.penable && apb_in.paddr != CTRL_ADDR &&
                       apb_in.paddr != STATUS_ADDR && apb_in.paddr != ERR_ADDR;

  assign prdata_out = r.prdata;
  assign tx_run_out = r.st == SCL_STARTED || r.st == SCL_CONNECT || r.st == SCL_RUN;
  assign tx_fct_out = r.tx_fct;
  assign tx_nch_valid_out = r.tx_nch_valid;
  assign tx_nch_out = r.tx_nch;
  assign tx_err_out = r.tx_err;
  assign link_err_out = r.lerr;
  assign link_err_code_out = r.lerr_code;
  assign state_out = r.st;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic trans;
    logic disc;
    logic rv;
    logic esc_e;
    logic got_null;
    logic plain_fct;
    logic nchar;
    logic eopish;
    logic par_e;
    logic cred_e;
    logic empty_e;
    logic seq_e;
    logic run_err;
    logic fault;
    logic link_on;
    logic go_hold;
    logic tmo;
    logic wr;
    logic [6:0] booked;
    logic [4:0] err_set;
    logic [4:0] err_clr;
    scl_err_t code;
    trans = 1'b0;
    disc = 1'b0;
    rv = 1'b0;
    esc_e = 1'b0;
    got_null = 1'b0;
    plain_fct = 1'b0;
    nchar = 1'b0;
    eopish = 1'b0;
    par_e = 1'b0;
    cred_e = 1'b0;
    empty_e = 1'b0;
    seq_e = 1'b0;
    run_err = 1'b0;
    fault = 1'b0;
    link_on = 1'b0;
    go_hold = 1'b0;
    tmo = 1'b0;
    wr = 1'b0;
    booked = 7'h00;
    err_set = 5'h00;
    err_clr = 5'h00;
    code = SCL_ERR_NONE;
    next_r = r;
    next_r.tx_fct = 1'b0;
    next_r.tx_nch_valid = 1'b0;
    next_r.tx_err = 1'b0;
    next_r.lerr = 1'b0;

    // line synchronisers in every state; disconnect timer in every state but fault hold, which clears and disarms it
    next_r.sy.d1 = rx_data_in;
    next_r.sy.d2 = r.sy.d1;
    next_r.sy.d3 = r.sy.d2;
    next_r.sy.s1 = rx_strobe_in;
    next_r.sy.s2 = r.sy.s1;
    next_r.sy.s3 = r.sy.s2;
    trans = (r.sy.d2 ^ r.sy.d3) | (r.sy.s2 ^ r.sy.s3);
    if (trans) begin
      next_r.disc_tmr = 5'h00;
      next_r.armed = 1'b1;
    end else if (r.armed && r.disc_tmr != DISC_CYC) begin
      next_r.disc_tmr = r.disc_tmr + 5'h01;
    end
    disc = r.armed && r.disc_tmr == DISC_CYC;

    // character classification; receiver is held in reset during fault hold
    rv = rx_ev_in.valid && r.st != SCL_HOLD;
    esc_e = rv && r.esc_pend && rx_ev_in.kind != SCL_RX_FCT;
    got_null = rv && r.esc_pend && rx_ev_in.kind == SCL_RX_FCT;
    plain_fct = rv && !r.esc_pend && rx_ev_in.kind == SCL_RX_FCT;
    nchar = rv && !r.esc_pend && (rx_ev_in.kind == SCL_RX_DATA ||
            rx_ev_in.kind == SCL_RX_EOP || rx_ev_in.kind == SCL_RX_EEP);
    eopish = rx_ev_in.kind == SCL_RX_EOP || rx_ev_in.kind == SCL_RX_EEP;
    par_e = rv && rx_ev_in.parity_err && r.null_seen;
    cred_e = r.st == SCL_RUN && nchar && r.rx_credit == 6'h00;
    empty_e = r.st == SCL_RUN && nchar && eopish && r.last_eop;
    seq_e = ((r.st == SCL_WAIT || r.st == SCL_READY || r.st == SCL_STARTED) &&
             (plain_fct || nchar)) || (r.st == SCL_CONNECT && nchar);
    if (rv) begin
      next_r.esc_pend = rx_ev_in.kind == SCL_RX_ESC;
    end
    if (got_null) begin
      next_r.null_seen = 1'b1;
    end
    if (nchar) begin
      next_r.last_eop = eopish;
      if (r.st == SCL_RUN && r.rx_credit != 6'h00) begin
        next_r.rx_credit = r.rx_credit - 6'h01;
      end
    end
    fault = (disc || par_e || esc_e || cred_e || empty_e || seq_e) && r.st != SCL_HOLD;

    // link error report, run state only
    run_err = r.st == SCL_RUN && (disc || par_e || esc_e || cred_e || empty_e);
    if (disc) begin
      code = SCL_ERR_DISC;
    end else if (par_e) begin
      code = SCL_ERR_PARITY;
    end else if (esc_e) begin
      code = SCL_ERR_ESC;
    end else if (cred_e) begin
      code = SCL_ERR_CREDIT;
    end else if (empty_e) begin
      code = SCL_ERR_EMPTY;
    end
    if (run_err) begin
      next_r.lerr = 1'b1;
      next_r.lerr_code = code;
      err_set = 5'(5'h01 << (3'(code) - 3'h1));
    end

    // credit granted to the far end
    booked = {1'b0, r.fct_pend, 3'h0} + {1'b0, r.rx_credit};
    if (rx_room_in && r.fct_pend != FCT_PEND_MAX && booked <= {1'b0, CREDIT_MAX - FCT_GRANT}) begin
      next_r.fct_pend = r.fct_pend + 3'h1;
    end
    if (fct_go) begin
      next_r.tx_fct = 1'b1;
      next_r.fct_pend = next_r.fct_pend - 3'h1;
      next_r.rx_credit = next_r.rx_credit + FCT_GRANT;
    end

    // credit granted by the far end
    if (plain_fct && (r.st == SCL_CONNECT || r.st == SCL_RUN) && r.tx_credit <= CREDIT_MAX - FCT_GRANT) begin
      next_r.tx_credit = r.tx_credit + FCT_GRANT;
    end

    // host characters
    if (nch_slot && tx_valid_in) begin
      if (tx_char_in[8] && tx_char_in[7:1] != 7'h00) begin
        next_r.tx_err = 1'b1;
        next_r.tx_halt = 1'b1;
      end else begin
        next_r.tx_nch_valid = 1'b1;
        next_r.tx_nch = tx_char_in;
        next_r.tx_credit = next_r.tx_credit - 6'h01;
      end
    end

    // exchange state sequencing
    link_on = !r.ctrl[CTRL_DISABLE_BIT] && (r.ctrl[CTRL_ENABLE_BIT] ||
              (r.ctrl[CTRL_AUTOSTART_BIT] && r.null_seen));
    tmo = r.tmr >= TOUT_CYC - 9'h001;
    next_r.tmr = r.tmr + 9'h001;
    unique case (r.st)
      SCL_HOLD: begin
        if (r.tmr >= HOLD_CYC - 9'h001) begin
          next_r.st = SCL_WAIT;
          next_r.tmr = 9'h000;
        end
      end
      SCL_WAIT: begin
        if (fault) begin
          go_hold = 1'b1;
        end else if (r.tmr >= WAIT_CYC - 9'h001) begin
          next_r.st = SCL_READY;
          next_r.tmr = 9'h000;
        end
      end
      SCL_READY: begin
        next_r.tmr = 9'h000;
        if (fault) begin
          go_hold = 1'b1;
        end else if (link_on) begin
          next_r.st = SCL_STARTED;
        end
      end
      SCL_STARTED: begin
        if (fault || !link_on || tmo) begin
          go_hold = 1'b1;
        end else if (r.null_seen) begin
          next_r.st = SCL_CONNECT;
          next_r.tmr = 9'h000;
        end
      end
      SCL_CONNECT: begin
        if (fault || !link_on || tmo) begin
          go_hold = 1'b1;
        end else if (plain_fct) begin
          next_r.st = SCL_RUN;
        end
      end
      SCL_RUN: begin
        next_r.tmr = 9'h000;
        if (fault || !link_on) begin
          go_hold = 1'b1;
        end
      end
      default: begin
        go_hold = 1'b1;
      end
    endcase

    // fault hold resets receiver, credit and transmit halt
    if (go_hold || r.st == SCL_HOLD) begin
      if (go_hold) begin
        next_r.st = SCL_HOLD;
        next_r.tmr = 9'h000;
      end
      next_r.armed = 1'b0;
      next_r.disc_tmr = 5'h00;
      next_r.null_seen = 1'b0;
      next_r.esc_pend = 1'b0;
      next_r.last_eop = 1'b0;
      next_r.tx_halt = 1'b0;
      next_r.tx_credit = 6'h00;
      next_r.rx_credit = 6'h00;
      next_r.fct_pend = 3'h0;
      next_r.tx_nch_valid = 1'b0;
      next_r.tx_fct = 1'b0;
    end

    // apb registers
    wr = apb_in.psel && apb_in.penable && apb_in.pwrite;
    if (wr && apb_in.paddr == CTRL_ADDR) begin
      next_r.ctrl = apb_in.pwdata[2:0];
    end
    if (wr && apb_in.paddr == ERR_ADDR) begin
      err_clr = apb_in.pwdata[4:0];
    end
    next_r.err_sticky = (r.err_sticky & ~err_clr) | err_set;
    if (apb_in.psel && !apb_in.penable) begin
      next_r.prdata = 32'h00000000;
      unique case (apb_in.paddr)
        CTRL_ADDR: next_r.prdata[2:0] = r.ctrl;
        STATUS_ADDR: begin
          next_r.prdata[STATUS_STATE_POS +: 6] = r.st;
          next_r.prdata[STATUS_NULL_POS] = r.null_seen;
          next_r.prdata[STATUS_HALT_POS] = r.tx_halt;
          next_r.prdata[STATUS_TXCRED_POS +: 6] = r.tx_credit;
          next_r.prdata[STATUS_RXCRED_POS +: 6] = r.rx_credit;
          next_r.prdata[STATUS_PEND_POS +: 3] = r.fct_pend;
        end
        ERR_ADDR: next_r.prdata[4:0] = r.err_sticky;
        default: next_r.prdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '{st: SCL_HOLD, ctrl: CTRL_RESET, err_sticky: ERR_RESET, lerr_code: SCL_ERR_NONE, default: '0};
    end else begin
      r <= next_r;
    end
  end
endmodule

// [rtl/scl_pkg.sv]
/*
  Shared constants and carrier types of the serial link credit and error handler.
  Assumes a 25 MHz system clock and a 32-bit APB register bus with byte addresses.
*/
package scl_pkg;
  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int DISC_TIME_NS = 850;
  localparam int HOLD_TIME_NS = 6400;
  localparam int WAIT_TIME_NS = 12800;
  localparam int TOUT_TIME_NS = 12800;
  localparam logic [4:0] DISC_CYC = 5'(DISC_TIME_NS / CLK_PERIOD_NS);
  localparam logic [8:0] HOLD_CYC = 9'(HOLD_TIME_NS / CLK_PERIOD_NS);
  localparam logic [8:0] WAIT_CYC = 9'(WAIT_TIME_NS / CLK_PERIOD_NS);
  localparam logic [8:0] TOUT_CYC = 9'(TOUT_TIME_NS / CLK_PERIOD_NS);

  // ==========================================================================
  // flow control
  // ==========================================================================
  localparam logic [5:0] FCT_GRANT = 6'h08;
  localparam logic [5:0] CREDIT_MAX = 6'h38;
  localparam logic [2:0] FCT_PEND_MAX = 3'h7;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] ERR_ADDR = 8'h08;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_AUTOSTART_BIT = 1;
  localparam int CTRL_DISABLE_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int STATUS_STATE_POS = 0;
  localparam int STATUS_NULL_POS = 6;
  localparam int STATUS_HALT_POS = 7;
  localparam int STATUS_TXCRED_POS = 8;
  localparam int STATUS_RXCRED_POS = 16;
  localparam int STATUS_PEND_POS = 24;
  localparam logic [4:0] ERR_RESET = 5'h00;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef enum logic [5:0] {
    SCL_HOLD    = 6'b000001,
    SCL_WAIT    = 6'b000010,
    SCL_READY   = 6'b000100,
    SCL_STARTED = 6'b001000,
    SCL_CONNECT = 6'b010000,
    SCL_RUN     = 6'b100000
  } scl_state_t;

  typedef enum logic [2:0] {
    SCL_RX_FCT  = 3'h0,
    SCL_RX_ESC  = 3'h1,
    SCL_RX_DATA = 3'h2,
    SCL_RX_EOP  = 3'h3,
    SCL_RX_EEP  = 3'h4
  } scl_rx_kind_t;

  typedef enum logic [2:0] {
    SCL_ERR_NONE   = 3'h0,
    SCL_ERR_DISC   = 3'h1,
    SCL_ERR_PARITY = 3'h2,
    SCL_ERR_ESC    = 3'h3,
    SCL_ERR_CREDIT = 3'h4,
    SCL_ERR_EMPTY  = 3'h5
  } scl_err_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } scl_apb_req_t;

  typedef struct packed {
    logic valid;
    scl_rx_kind_t kind;
    logic parity_err;
  } scl_rx_ev_t;

  typedef struct packed {
    logic d1;
    logic d2;
    logic d3;
    logic s1;
    logic s2;
    logic s3;
  } scl_sync_t;

  typedef struct packed {
    scl_state_t st;
    logic [8:0] tmr;
    scl_sync_t sy;
    logic [4:0] disc_tmr;
    logic armed;
    logic null_seen;
    logic esc_pend;
    logic last_eop;
    logic tx_halt;
    logic [5:0] tx_credit;
    logic [5:0] rx_credit;
    logic [2:0] fct_pend;
    logic [2:0] ctrl;
    logic [4:0] err_sticky;
    logic tx_fct;
    logic tx_nch_valid;
    logic [8:0] tx_nch;
    logic tx_err;
    logic lerr;
    scl_err_t lerr_code;
    logic [31:0] prdata;
  } scl_regs_t;
endpackage

// [tb/scl_link_properties.sv]
/*
  Concurrent checks on the link end ports.
  Assumes a bind into scl_link.
*/
`timescale 1ns/1ps
module scl_link_properties (
  input wire logic mclk_in, // clock
  input wire logic rst_in, // reset, active high
  input wire scl_pkg::scl_rx_ev_t rx_ev_in, // rx char
  input wire logic tx_valid_in, // host offer
  input wire logic [8:0] tx_char_in, // host char
  input wire logic tx_ready_out, // host char taken
  input wire logic tx_link_ready_in, // encoder ready
  input wire logic tx_run_out, // tx enabled
  input wire logic tx_fct_out, // fct pulse
  input wire logic tx_nch_valid_out, // char pulse
  input wire logic [8:0] tx_nch_out, // char sent
  input wire logic tx_err_out, // bad char pulse
  input wire logic link_err_out, // link error pulse
  input wire scl_pkg::scl_err_t link_err_code_out, // link error type
  input wire scl_pkg::scl_state_t state_out // state
);
  import scl_pkg::*;
  // ==========================================================================
  // properties
  // ==========================================================================
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_fct_state; tx_fct_out |-> state_out == SCL_CONNECT || state_out == SCL_RUN; endproperty
  a_fct_state: assert property (p_fct_state) else $error("fct before connect");
  property p_ready_gate; tx_ready_out |-> state_out == SCL_RUN && tx_link_ready_in && !tx_nch_valid_out; endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("host ready wrongly");
  property p_nch_pass; tx_valid_in && tx_ready_out && !tx_char_in[8] |=> tx_nch_valid_out && tx_nch_out == $past(tx_char_in); endproperty
  a_nch_pass: assert property (p_nch_pass) else $error("char not sent");
  property p_bad_char;
    tx_valid_in && tx_ready_out && tx_char_in[8] && tx_char_in[7:1] != 7'h00 |=>
      (tx_err_out && !tx_nch_valid_out) ##1 (!tx_ready_out) [*8];
  endproperty
  a_bad_char: assert property (p_bad_char) else $error("bad char not refused");
  property p_parity_hold; rx_ev_in.valid && rx_ev_in.parity_err && state_out == SCL_RUN |=> state_out == SCL_HOLD; endproperty
  a_parity_hold: assert property (p_parity_hold) else $error("parity not recovered");
  property p_lerr_src; link_err_out |-> state_out == SCL_HOLD && ($past(state_out) == SCL_RUN || $past(state_out, 2) == SCL_RUN); endproperty
  a_lerr_src: assert property (p_lerr_src) else $error("link error outside run");
  property p_lerr_pulse; link_err_out |-> (link_err_code_out != SCL_ERR_NONE && link_err_code_out <= SCL_ERR_EMPTY) ##1 !link_err_out; endproperty
  a_lerr_pulse: assert property (p_lerr_pulse) else $error("bad link error pulse");
  property p_silent; state_out == SCL_HOLD || state_out == SCL_WAIT || state_out == SCL_READY |-> !tx_run_out; endproperty
  a_silent: assert property (p_silent) else $error("tx runs in reset");
  property p_start_tout; $rose(state_out == SCL_STARTED) |-> $past(state_out) == SCL_READY ##[1:322] state_out != SCL_STARTED; endproperty
  a_start_tout: assert property (p_start_tout) else $error("started not left");
  property p_hold_exit; $fell(state_out == SCL_HOLD) |-> state_out == SCL_WAIT; endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("hold not to wait");
  property p_ready_entry; $rose(state_out == SCL_READY) |-> $past(state_out) == SCL_WAIT; endproperty
  a_ready_entry: assert property (p_ready_entry) else $error("ready not from wait");
endmodule

bind scl_link scl_link_properties u_props (.mclk_in, .rst_in, .rx_ev_in, .tx_valid_in, .tx_char_in, .tx_ready_out,
  .tx_link_ready_in, .tx_run_out, .tx_fct_out, .tx_nch_valid_out, .tx_nch_out, .tx_err_out, .link_err_out,
  .link_err_code_out, .state_out);

// [tb/scl_peer.sv]
/*
  Far end of the link: toggles the lines and hands decoded characters over.
  Assumes tb drives it through its tasks.
*/
`timescale 1ns/1ps
module scl_peer (
  input wire logic mclk_in, // clock
  input wire logic run_in, // near end tx on
  output logic data_out, // data line
  output logic strobe_out, // strobe line
  output scl_pkg::scl_rx_ev_t ev_out // char pulse
);
  import scl_pkg::*;
  logic talk;
  logic ph;
  // one bit per 160 ns; lines still when silent
  initial begin
    talk = 1'h0;
    ph = 1'h0;
    data_out = 1'h0;
    strobe_out = 1'h0;
    ev_out = '0;
    #13;
    forever begin
      #160;
      if (talk) begin
        if (ph) data_out <= ~data_out;
        else strobe_out <= ~strobe_out;
        ph <= ~ph;
      end
    end
  end
  // near end silence stops this end
  always @(negedge run_in) talk = 1'h0;
  task automatic set_talk(input logic v);
    talk = v;
  endtask
  task automatic send(input scl_rx_kind_t k, input logic perr);
    @(posedge mclk_in);
    ev_out <= '{1'h1, k, perr};
    @(posedge mclk_in);
    ev_out <= '0;
  endtask
  task automatic send_null();
    send(SCL_RX_ESC, 1'h0);
    send(SCL_RX_FCT, 1'h0);
  endtask
  // credit only once near end sends nulls
  task automatic send_fct();
    if (run_in === 1'h1) send(SCL_RX_FCT, 1'h0);
  endtask
endmodule

// [tb/tb.sv]
/*
  Self-checking bench for scl_link.
  Assumes scl_pkg, scl_link, scl_peer and the checker compile first.
*/
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin errors++; $display("CHECK FAILED %0t %s", $time, msg); end end
module tb;
  import scl_pkg::*;
  logic mclk_in, rst_in, pready, pslverr, rx_data, rx_strobe, rx_room, tx_valid, tx_ready, tx_link_ready;
  logic tx_run, tx_fct, nch_valid, tx_err, lerr;
  logic [31:0] prdata;
  logic [8:0] tx_char, nch;
  scl_apb_req_t apb;
  scl_rx_ev_t rx_ev;
  scl_err_t lerr_code, last_code;
  scl_state_t st;
  int errors = 0, n_tests = 0, n_fct = 0, n_nch = 0, n_lerr = 0, n_terr = 0, waited, e, k, l0, f0;
  scl_link DUT (.mclk_in(mclk_in), .rst_in(rst_in), .apb_in(apb), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rx_data_in(rx_data), .rx_strobe_in(rx_strobe), .rx_ev_in(rx_ev), .rx_room_in(rx_room),
    .tx_valid_in(tx_valid), .tx_char_in(tx_char), .tx_ready_out(tx_ready), .tx_link_ready_in(tx_link_ready),
    .tx_run_out(tx_run), .tx_fct_out(tx_fct), .tx_nch_valid_out(nch_valid), .tx_nch_out(nch), .tx_err_out(tx_err),
    .link_err_out(lerr), .link_err_code_out(lerr_code), .state_out(st));
  scl_peer peer (.mclk_in(mclk_in), .run_in(tx_run), .data_out(rx_data), .strobe_out(rx_strobe), .ev_out(rx_ev));
  initial begin
    mclk_in = 1'h0;
    forever #20 mclk_in = ~mclk_in;
  end
  // output pulse counters
  always @(posedge mclk_in) begin
    n_fct <= n_fct + int'(tx_fct === 1'h1);
    n_nch <= n_nch + int'(nch_valid === 1'h1);
    n_terr <= n_terr + int'(tx_err === 1'h1);
    n_lerr <= n_lerr + int'(lerr === 1'h1);
    if (lerr === 1'h1) last_code <= lerr_code;
  end
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic wrap_up();
    $display("checks: %0d, mismatches: %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb_x(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
    @(posedge mclk_in);
    apb <= '{1'h1, 1'h0, w, a, wd};
    @(posedge mclk_in);
    apb.penable <= 1'h1;
    do @(posedge mclk_in); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    logic er;
    apb_x(1'h0, a, 32'h0, d, er);
    `CHK(d & m, exp, msg)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic er;
    apb_x(1'h1, a, wd, d, er);
  endtask
  task automatic wait_st(input scl_state_t s, input int n, input string msg);
    waited = 0;
    while (st !== s && waited < n) begin
      @(posedge mclk_in);
      waited++;
    end
    `CHK(st, s, msg)
  endtask
  task automatic send_nch(input logic [8:0] c);
    int i;
    i = 0;
    @(posedge mclk_in);
    tx_valid <= 1'h1;
    tx_char <= c;
    do @(posedge mclk_in); while (tx_ready !== 1'h1 && ++i < 30);
    tx_valid <= 1'h0;
  endtask
  task automatic bring_up();
    wait_st(SCL_STARTED, 900, "started");
    peer.set_talk(1'h1);
    peer.send_null();
    wait_st(SCL_CONNECT, 20, "connect");
    f0 = n_fct;
    @(posedge mclk_in);
    rx_room <= 1'h1;
    @(posedge mclk_in);
    rx_room <= 1'h0;
    for (k = 0; k < 20 && n_fct == f0; k++) @(posedge mclk_in);
    `CHK(n_fct, f0 + 1, "one fct per room")
    peer.send_fct();
    wait_st(SCL_RUN, 20, "run");
  endtask
  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    repeat (40000) @(posedge mclk_in);
    errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    logic [31:0] d;
    logic er;
    rst_in = 1'h1;
    apb = '0;
    rx_room = 1'h0;
    tx_valid = 1'h0;
    tx_char = 9'h000;
    tx_link_ready = 1'h1;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'h0;
    `CHK(st, SCL_HOLD, "reset state")
    rd_chk(CTRL_ADDR, 32'h00000007, 32'h00000000, "ctrl reset");
    rd_chk(STATUS_ADDR, 32'h0000003F, 32'h00000001, "status reset");
    apb_x(1'h0, 8'h0C, 32'h0, d, er);
    `CHK({er, d}, 33'h100000000, "unmapped address")
    wait_st(SCL_WAIT, 170, "wait after hold");
    wait_st(SCL_READY, 330, "ready after wait");
    repeat (100) @(posedge mclk_in);
    `CHK(st, SCL_READY, "silent line before first bit")
    $display("test done: reset sequence");
    wr(CTRL_ADDR, 32'h00000001);
    wait_st(SCL_STARTED, 5, "enabled start");
    wait_st(SCL_HOLD, 340, "start timeout");
    `CHK(waited > 300, 1'h1, "timeout length")
    wait_st(SCL_STARTED, 900, "restart");
    peer.send(SCL_RX_DATA, 1'h0);
    wait_st(SCL_HOLD, 5, "sequence error");
    `CHK(n_lerr, 0, "no link error in start-up")
    $display("test done: start-up faults");
    bring_up();
    rd_chk(STATUS_ADDR, 32'h003F3F00, 32'h00080800, "credits in run");
    for (e = 0; e < 8; e++) send_nch(9'(e + 16));
    repeat (3) @(posedge mclk_in);
    `CHK(n_nch, 8, "eight characters sent")
    tx_valid <= 1'h1;
    repeat (4) @(posedge mclk_in);
    `CHK(tx_ready, 1'h0, "zero credit blocks host")
    tx_valid <= 1'h0;
    peer.send(SCL_RX_FCT, 1'h0);
    repeat (3) @(posedge mclk_in);
    `CHK(tx_ready, 1'h1, "fct restores credit")
    send_nch(9'h1FF);
    repeat (3) @(posedge mclk_in);
    `CHK({n_terr, n_nch, tx_ready}, {32'd1, 32'd8, 1'h0}, "invalid character halts")
    $display("test done: credit flow");
    for (e = 1; e <= 5; e++) begin
      l0 = n_lerr;
      case (e)
        1: peer.set_talk(1'h0);
        2: peer.send(SCL_RX_DATA, 1'h1);
        3: begin
          peer.send(SCL_RX_ESC, 1'h0);
          peer.send(SCL_RX_DATA, 1'h0);
        end
        4: for (k = 0; k < 9; k++) peer.send(SCL_RX_DATA, 1'h0);
        default: begin
          peer.send(SCL_RX_EOP, 1'h0);
          peer.send(SCL_RX_EEP, 1'h0);
        end
      endcase
      wait_st(SCL_HOLD, 40, "error recovery");
      repeat (3) @(posedge mclk_in);
      `CHK(n_lerr, l0 + 1, "one link error")
      `CHK(last_code, scl_err_t'(e), "link error code")
      rd_chk(STATUS_ADDR, 32'h003F3F00, 32'h00000000, "credits cleared");
      bring_up();
    end
    rd_chk(ERR_ADDR, 32'h0000001F, 32'h0000001F, "sticky errors");
    wr(ERR_ADDR, 32'h0000001F);
    rd_chk(ERR_ADDR, 32'h0000001F, 32'h00000000, "errors cleared");
    $display("test done: run errors");
    l0 = n_lerr;
    wr(CTRL_ADDR, 32'h00000005);
    wait_st(SCL_HOLD, 5, "disable stops link");
    wait_st(SCL_WAIT, 170, "disabled wait");
    peer.set_talk(1'h1);
    peer.send_null();
    rd_chk(STATUS_ADDR, 32'h00000040, 32'h00000040, "null seen while disabled");
    wait_st(SCL_READY, 330, "disabled ready");
    repeat (50) @(posedge mclk_in);
    `CHK(st, SCL_READY, "disabled end stays ready")
    peer.set_talk(1'h0);
    wait_st(SCL_HOLD, 40, "disconnect while disabled");
    `CHK(n_lerr, l0, "no link error outside run")
    $display("test done: disabled end");
    wrap_up();
  end
endmodule
